// ---- design/decisec_timer.sv ----
// saturating counter of 0.1 s ticks with a limit compare
`timescale 1ns/1ps
module decisec_timer (
	input wire logic mclk_in, // system clock
	input wire logic nrst_in, // async reset, low
	input wire logic clear_in, // synchronous clear
	input wire logic tick_in, // 0.1 s tick
	input wire logic run_in, // count enable
	input wire logic [15:0] limit_in, // limit in ticks
	output logic expired_out // count reached limit
);
	logic [15:0] cnt_reg;

	// the clear wins over a tick so a restarted interval starts at zero
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_reg <= 16'h0;
		end else if (clear_in) begin
			cnt_reg <= 16'h0;
		end else if (run_in && tick_in && cnt_reg != 16'hFFFF) begin
			cnt_reg <= cnt_reg + 16'h1;
		end
	end

	assign expired_out = (cnt_reg >= limit_in);
endmodule // decisec_timer

// ---- design/restart_pkg.sv ----
// types shared by the restart sequencer files
package restart_pkg;
	typedef enum logic [6:0] {
		ST_STOP = 7'h01,
		ST_RUN = 7'h02,
		ST_OUTAGE = 7'h04,
		ST_WAIT = 7'h08,
		ST_HOLD = 7'h10,
		ST_MATCH = 7'h20,
		ST_TRIP = 7'h40
	} seq_state_t;
	typedef enum logic [1:0] {
		K_NONE = 2'h0,
		K_PLAIN = 2'h1,
		K_ACTIVE = 2'h2
	} restart_kind_t;
endpackage

// ---- design/restart_regs.svh ----
// register map, field positions, reset values and timing counts
`ifndef RESTART_REGS_SVH
`define RESTART_REGS_SVH
// ----------------
// register offsets (byte addresses)
// ----------------
`define CTRL_OFF 8'h00
`define TIME_OFF 8'h04
`define MATCH_OFF 8'h08
`define STAT_OFF 8'h0C
`define IRQ_STAT_OFF 8'h10
`define IRQ_MASK_OFF 8'h14
// ----------------
// field positions
// ----------------
`define OUT_MODE_LO 0
`define OC_MODE_LO 4
`define COAST_MODE_LO 8
`define RST_MODE_LO 10
`define RUN_SRC_LO 12
`define STOP_ERR_BIT 14
`define LIMIT_SEL_BIT 15
`define INDUCTION_BIT 16
`define LIGHT_DUTY_BIT 17
`define SPEED_SEL_LO 18
`define OC_RETRY_LO 20
`define ALLOW_LO 0
`define WAIT_LO 16
`define CUR_LIM_LO 0
`define DECEL_LO 16
`define IRQ_OUTAGE 0
`define IRQ_RESTART 1
`define IRQ_TRIP 2
// ----------------
// reset values
// ----------------
`define CTRL_RST 32'h0010_0000
`define TIME_RST 32'h000A_000A
`define MATCH_RST 32'h001E_000F
// ----------------------------------------------------------------
// selector codes and ranges (times in 0.1 s, current in 0.1 x)
// ----------------------------------------------------------------
`define OUT_PLAIN 3'h2
`define OUT_ACTIVE 3'h4
`define HOLD_PLAIN 3'h1
`define HOLD_ACTIVE 3'h2
`define RUN_SRC_KEYPAD 2'h2
`define SPEED_SHUTDOWN 2'h0
`define SPEED_MAX 2'h1
`define LIMIT_SEL_16 1'h0
`define OUTAGE_RETRY_MAX 5'h10
`define ALLOW_MIN 16'h0003
`define ALLOW_MAX 16'h00FA
`define WAIT_MIN 16'h0003
`define WAIT_MAX 16'h03E8
`define CUR_MIN 16'h0002
`define CUR_MAX_ND 16'h0014
`define CUR_MAX_LD 16'h000F
`define DECEL_MIN 16'h0001
`define DECEL_MAX 16'h7530
`define OC_RETRY_MIN 16'h0001
`define OC_RETRY_MAX 16'h0003
// ----------------
// trip codes and timing
// ----------------
`define TRIP_NONE 4'h0
`define TRIP_OUTAGE_TIME 4'h1
`define TRIP_OUTAGE_COUNT 4'h2
`define TRIP_OC 4'h3
`define UNDERVOLTAGE_TRIP_CODE 4'h9
`define CLK_PERIOD_NS 25
`define TICK_NS 100000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define UV_LIMIT_S 40
`define TICKS_PER_S 10
`define UV_LIMIT_TICKS 16'(`UV_LIMIT_S * `TICKS_PER_S)
`endif

// ---- design/restart_sequencer.sv ----
// restart sequencer for a motor drive with an APB register file
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "restart_regs.svh"
module restart_sequencer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic mclk_in, // 40 MHz clock
	input wire logic nrst_in, // async reset, low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb enable
	input wire logic pwrite_in, // apb write
	input wire logic [7:0] paddr_in, // apb address
	input wire logic [31:0] pwdata_in, // apb write data
	output logic [31:0] prdata_out, // apb read data
	output logic pready_out, // apb ready
	output logic pslverr_out, // apb error
	output logic irq_out, // level interrupt
	input wire logic run_terminal_in, // terminal run
	input wire logic keypad_run_in, // keypad run press
	input wire logic keypad_stop_in, // keypad stop press
	input wire logic coast_stop_input_in, // free-run stop
	input wire logic reset_input_in, // reset input
	input wire logic power_fail_in, // outage or undervolt
	input wire logic overcurrent_in, // overcurrent pulse
	input wire logic overvoltage_in, // overvoltage pulse
	input wire logic [15:0] output_freq_in, // output freq
	input wire logic [15:0] max_freq_in, // maximum freq
	input wire logic [15:0] command_freq_in, // command freq
	output logic run_cmd_out, // run command
	output logic drive_enable_out, // output stage on
	output logic matching_active_out, // matching phase
	output logic [15:0] start_freq_out, // matching start
	output logic [4:0] current_limit_out, // 0.1 x rated
	output logic [14:0] decel_time_out, // 0.1 s units
	output logic trip_out, // tripped
	output logic [3:0] trip_code_out // trip cause
);
	import restart_pkg::*;

	// ----------------
	// helper functions
	// ----------------
	// maps a selector to a restart kind; active falls back to plain
	// on a non-induction motor rather than refusing the restart
	function automatic restart_kind_t kind_of(input logic [2:0] code,
			input logic power_grp, input logic induction);
		restart_kind_t k;
		k = K_NONE;
		if (power_grp) begin
			if (code == `OUT_PLAIN) k = K_PLAIN;
			else if (code == `OUT_ACTIVE) k = K_ACTIVE;
		end else begin
			if (code == `HOLD_PLAIN) k = K_PLAIN;
			else if (code == `HOLD_ACTIVE) k = K_ACTIVE;
		end
		if (k == K_ACTIVE && !induction) k = K_PLAIN;
		return k;
	endfunction

	function automatic logic [15:0] clamp16(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] r;
		r = v;
		if (v < lo) r = lo;
		else if (v > hi) r = hi;
		return r;
	endfunction

	// ----------------
	// declarations
	// ----------------
	logic [31:0] ctrl_reg;
	logic [31:0] time_reg;
	logic [31:0] match_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	seq_state_t state_reg;
	seq_state_t prev_state_reg;
	restart_kind_t kind_reg;
	logic hold_coast_reg;
	logic resume_reg;
	logic keypad_run_reg;
	logic [4:0] outage_cnt_reg;
	logic [1:0] oc_cnt_reg;
	logic [15:0] shutdown_freq_reg;
	logic tick;
	logic tmr_expired;
	logic uv_expired;
	logic tmr_clear;
	logic tmr_run;
	logic [15:0] tmr_limit;
	logic run_active;
	logic hold_active;
	logic keypad_src;
	logic fault_ev;
	logic oc_retry_ok;
	logic outage_ok;
	logic [15:0] allow_t;
	logic [15:0] wait_t;
	logic [15:0] oc_limit;
	logic [15:0] cur_max;
	restart_kind_t out_kind;
	restart_kind_t oc_kind;
	restart_kind_t hold_kind;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic [31:0] rd_data;
	logic rd_err;
	logic [2:0] irq_ev;

	// ----------------
	// settings decode
	// ----------------
	assign keypad_src = (ctrl_reg[`RUN_SRC_LO +: 2] == `RUN_SRC_KEYPAD);
	assign run_active = keypad_src ? keypad_run_reg : run_terminal_in;
	assign hold_active = coast_stop_input_in | reset_input_in;
	assign fault_ev = overcurrent_in | overvoltage_in;
	assign allow_t = clamp16({8'h0, time_reg[`ALLOW_LO +: 8]},
		`ALLOW_MIN, `ALLOW_MAX);
	assign wait_t = clamp16({6'h0, time_reg[`WAIT_LO +: 10]},
		`WAIT_MIN, `WAIT_MAX);
	assign oc_limit = clamp16({14'h0, ctrl_reg[`OC_RETRY_LO +: 2]},
		`OC_RETRY_MIN, `OC_RETRY_MAX);
	assign cur_max = ctrl_reg[`LIGHT_DUTY_BIT] ? `CUR_MAX_LD : `CUR_MAX_ND;
	assign out_kind = kind_of(ctrl_reg[`OUT_MODE_LO +: 3], 1'b1,
		ctrl_reg[`INDUCTION_BIT]);
	assign oc_kind = kind_of(ctrl_reg[`OC_MODE_LO +: 3], 1'b1,
		ctrl_reg[`INDUCTION_BIT]);
	// power-on takes the reset-release selector, as after a long outage
	assign hold_kind = hold_coast_reg ?
		kind_of({1'b0, ctrl_reg[`COAST_MODE_LO +: 2]}, 1'b0,
			ctrl_reg[`INDUCTION_BIT]) :
		kind_of({1'b0, ctrl_reg[`RST_MODE_LO +: 2]}, 1'b0,
			ctrl_reg[`INDUCTION_BIT]);
	assign oc_retry_ok = (oc_kind != K_NONE) &&
		({14'h0, oc_cnt_reg} < oc_limit);
	assign outage_ok = (out_kind != K_NONE) &&
		!(ctrl_reg[`LIMIT_SEL_BIT] == `LIMIT_SEL_16 &&
		outage_cnt_reg == `OUTAGE_RETRY_MAX);

	// ----------------
	// timers
	// ----------------
	tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.tick_out(tick)
	);

	// one timer serves the outage window, the retry wait and the hold
	// wait; it restarts on every state change
	assign tmr_clear = (state_reg != prev_state_reg) | reset_input_in |
		(state_reg == ST_HOLD && !run_active);
	assign tmr_run = (state_reg == ST_OUTAGE) || (state_reg == ST_WAIT) ||
		(state_reg == ST_HOLD);
	assign tmr_limit = (state_reg == ST_OUTAGE) ? allow_t : wait_t;

	decisec_timer u_event_tmr (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.clear_in(tmr_clear),
		.tick_in(tick),
		.run_in(tmr_run),
		.limit_in(tmr_limit),
		.expired_out(tmr_expired)
	);

	// long undervoltage guard runs whatever the state or selector
	decisec_timer u_uv_tmr (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.clear_in(!power_fail_in | reset_input_in),
		.tick_in(tick),
		.run_in(1'b1),
		.limit_in(`UV_LIMIT_TICKS),
		.expired_out(uv_expired)
	);

	// ----------------
	// run command
	// ----------------
	// an outage or overcurrent never touches the latch, so a keypad
	// run survives those restarts
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			keypad_run_reg <= 1'b0;
		end else if (hold_active) begin
			keypad_run_reg <= 1'b0;
		end else if (keypad_run_in) begin
			keypad_run_reg <= 1'b1;
		end else if (keypad_stop_in) begin
			keypad_run_reg <= 1'b0;
		end
	end

	// ----------------
	// sequencer state
	// ----------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= ST_HOLD;
			hold_coast_reg <= 1'b0;
			kind_reg <= K_NONE;
			resume_reg <= 1'b0;
			trip_code_out <= `TRIP_NONE;
		end else if (reset_input_in) begin
			state_reg <= ST_HOLD;
			hold_coast_reg <= 1'b0;
			trip_code_out <= `TRIP_NONE;
		end else if (uv_expired && state_reg != ST_TRIP) begin
			state_reg <= ST_TRIP;
			trip_code_out <= `UNDERVOLTAGE_TRIP_CODE;
		end else begin
			case (state_reg)
			ST_STOP: begin
				if (power_fail_in) begin
					resume_reg <= 1'b0;
					if (ctrl_reg[`STOP_ERR_BIT]) begin
						state_reg <= ST_TRIP;
						trip_code_out <= `UNDERVOLTAGE_TRIP_CODE;
					end else begin
						state_reg <= ST_OUTAGE;
					end
				end else if (coast_stop_input_in) begin
					state_reg <= ST_HOLD;
					hold_coast_reg <= 1'b1;
				end else if (run_active) begin
					state_reg <= ST_RUN;
				end
			end
			ST_RUN, ST_MATCH: begin
				if (coast_stop_input_in) begin
					state_reg <= ST_HOLD;
					hold_coast_reg <= 1'b1;
				end else if (power_fail_in) begin
					resume_reg <= 1'b1;
					kind_reg <= out_kind;
					if (outage_ok) begin
						state_reg <= ST_OUTAGE;
					end else begin
						state_reg <= ST_TRIP;
						trip_code_out <= `TRIP_OUTAGE_COUNT;
					end
				end else if (fault_ev) begin
					kind_reg <= oc_kind;
					if (oc_retry_ok) begin
						state_reg <= ST_WAIT;
					end else begin
						state_reg <= ST_TRIP;
						trip_code_out <= `TRIP_OC;
					end
				end else if (!run_active) begin
					state_reg <= ST_STOP;
				end else if (state_reg == ST_MATCH &&
						output_freq_in == command_freq_in) begin
					state_reg <= ST_RUN;
				end
			end
			ST_OUTAGE: begin
				if (tmr_expired) begin
					state_reg <= ST_TRIP;
					trip_code_out <= `TRIP_OUTAGE_TIME;
				end else if (!power_fail_in) begin
					state_reg <= resume_reg ? ST_WAIT : ST_STOP;
				end
			end
			ST_WAIT: begin
				if (power_fail_in) begin
					state_reg <= ST_OUTAGE;
				end else if (tmr_expired) begin
					state_reg <= ST_MATCH;
				end
			end
			ST_HOLD: begin
				if (!hold_active && run_active) begin
					if (hold_kind == K_NONE) begin
						state_reg <= ST_RUN;
					end else if (tmr_expired) begin
						state_reg <= ST_MATCH;
						kind_reg <= hold_kind;
					end
				end
			end
			ST_TRIP: begin
				state_reg <= ST_TRIP;
			end
			default: begin
				state_reg <= ST_STOP;
			end
			endcase
		end
	end

	// ----------------
	// retry counters
	// ----------------
	// outage count clears only on reset input or loss of logic supply
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			outage_cnt_reg <= 5'h0;
			oc_cnt_reg <= 2'h0;
		end else if (reset_input_in) begin
			outage_cnt_reg <= 5'h0;
			oc_cnt_reg <= 2'h0;
		end else if ((state_reg == ST_RUN || state_reg == ST_MATCH) &&
				!coast_stop_input_in) begin
			if (power_fail_in && outage_ok &&
					outage_cnt_reg != `OUTAGE_RETRY_MAX) begin
				outage_cnt_reg <= outage_cnt_reg + 5'h1;
			end else if (!power_fail_in && fault_ev && oc_retry_ok) begin
				oc_cnt_reg <= oc_cnt_reg + 2'h1;
			end
		end
	end

	// ----------------
	// drive outputs
	// ----------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prev_state_reg <= ST_HOLD;
			shutdown_freq_reg <= 16'h0;
			run_cmd_out <= 1'b0;
			drive_enable_out <= 1'b0;
			matching_active_out <= 1'b0;
			trip_out <= 1'b0;
			current_limit_out <= 5'h0;
			decel_time_out <= 15'h0;
		end else begin
			prev_state_reg <= state_reg;
			if (state_reg == ST_RUN || state_reg == ST_MATCH) begin
				shutdown_freq_reg <= output_freq_in;
			end
			run_cmd_out <= run_active;
			drive_enable_out <= (state_reg == ST_RUN) ||
				(state_reg == ST_MATCH);
			matching_active_out <= (state_reg == ST_MATCH);
			trip_out <= (state_reg == ST_TRIP);
			current_limit_out <= 5'(clamp16(
				{11'h0, match_reg[`CUR_LIM_LO +: 5]},
				`CUR_MIN, cur_max));
			decel_time_out <= 15'(clamp16(
				{1'h0, match_reg[`DECEL_LO +: 15]},
				`DECEL_MIN, `DECEL_MAX));
		end
	end

	// start speed is fixed on the entry into matching
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			start_freq_out <= 16'h0;
		end else if (state_reg == ST_MATCH && prev_state_reg != ST_MATCH) begin
			if (kind_reg != K_ACTIVE ||
					ctrl_reg[`SPEED_SEL_LO +: 2] == `SPEED_SHUTDOWN) begin
				start_freq_out <= shutdown_freq_reg;
			end else if (ctrl_reg[`SPEED_SEL_LO +: 2] == `SPEED_MAX) begin
				start_freq_out <= max_freq_in;
			end else begin
				start_freq_out <= command_freq_in;
			end
		end
	end

	// ----------------
	// apb slave
	// ----------------
	// no wait state: ready is raised for the first access cycle only
	assign acc = psel_in && penable_in && pready_out;
	assign wr_acc = acc && pwrite_in;
	assign rd_acc = acc && !pwrite_in;

	always_comb begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		if (paddr_in == `CTRL_OFF) begin
			rd_data = ctrl_reg;
		end else if (paddr_in == `TIME_OFF) begin
			rd_data = time_reg;
		end else if (paddr_in == `MATCH_OFF) begin
			rd_data = match_reg;
		end else if (paddr_in == `STAT_OFF) begin
			rd_data = {6'h0, oc_cnt_reg, 3'h0, outage_cnt_reg, 3'h0,
				run_active, trip_code_out, 1'b0, state_reg};
		end else if (paddr_in == `IRQ_STAT_OFF) begin
			rd_data = {29'h0, irq_stat_reg};
		end else if (paddr_in == `IRQ_MASK_OFF) begin
			rd_data = {29'h0, irq_mask_reg};
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			prdata_out <= (psel_in && !penable_in && !pwrite_in) ?
				rd_data : 32'h0;
			pslverr_out <= psel_in && !penable_in && rd_err;
		end
	end

	// settings registers take effect at the access edge
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_reg <= `CTRL_RST;
			time_reg <= `TIME_RST;
			match_reg <= `MATCH_RST;
			irq_mask_reg <= 3'h0;
		end else if (wr_acc) begin
			if (paddr_in == `CTRL_OFF) begin
				ctrl_reg <= pwdata_in;
			end else if (paddr_in == `TIME_OFF) begin
				time_reg <= pwdata_in;
			end else if (paddr_in == `MATCH_OFF) begin
				match_reg <= pwdata_in;
			end else if (paddr_in == `IRQ_MASK_OFF) begin
				irq_mask_reg <= pwdata_in[2:0];
			end
		end
	end

	// ----------------
	// interrupts
	// ----------------
	// a new event in the read cycle survives the read-clear
	always_comb begin
		irq_ev = 3'h0;
		irq_ev[`IRQ_OUTAGE] = (state_reg == ST_OUTAGE) &&
			(prev_state_reg != ST_OUTAGE);
		irq_ev[`IRQ_RESTART] = (state_reg == ST_MATCH) &&
			(prev_state_reg != ST_MATCH);
		irq_ev[`IRQ_TRIP] = (state_reg == ST_TRIP) &&
			(prev_state_reg != ST_TRIP);
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_stat_reg <= 3'h0;
			irq_out <= 1'b0;
		end else begin
			if (rd_acc && paddr_in == `IRQ_STAT_OFF) begin
				irq_stat_reg <= irq_ev;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_ev;
			end
			irq_out <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule // restart_sequencer

// ---- design/tick_divider.sv ----
// divides the system clock into a one-cycle 0.1 s tick
`timescale 1ns/1ps
module tick_divider #(
	parameter int TICK_CYCLES = 4000000
) (
	input wire logic mclk_in, // system clock
	input wire logic nrst_in, // async reset, low
	output logic tick_out // one-cycle tick
);
	logic [22:0] cnt_reg;

	// free-running divider, the tick lands on the wrap cycle
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_reg <= 23'h0;
			tick_out <= 1'b0;
		end else if (cnt_reg == 23'(TICK_CYCLES - 1)) begin
			cnt_reg <= 23'h0;
			tick_out <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 23'h1;
			tick_out <= 1'b0;
		end
	end
endmodule // tick_divider

// ---- verification/motor_supply_model.sv ----
// mains and coasting motor model on the far side of the sequencer
`timescale 1ns/1ps
module motor_supply_model (
	input wire logic mclk_in, // system clock
	input wire logic nrst_in, // async reset, low
	input wire logic outage_req_in, // bench asks for an outage
	input wire logic drive_enable_in, // output stage on
	input wire logic matching_in, // matching phase
	input wire logic [2:0] lag_in, // catch-up delay
	input wire logic [15:0] run_freq_in, // speed while driven
	input wire logic [15:0] cmd_freq_in, // command frequency
	output logic power_fail_out, // mains missing
	output logic [15:0] freq_out // measured output frequency
);
	logic [2:0] lag_reg;
	// --------------------------------------------
	// mains and motor speed
	// --------------------------------------------
	// a coasting motor keeps its speed; varied lag gives slow catch-up
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			power_fail_out <= 1'h0;
			lag_reg <= 3'h0;
			freq_out <= 16'h0000;
		end else begin
			power_fail_out <= outage_req_in;
			lag_reg <= matching_in ? lag_reg + 3'h1 : 3'h0;
			if (matching_in && lag_reg == lag_in)
				freq_out <= cmd_freq_in;
			else if (drive_enable_in && !matching_in)
				freq_out <= run_freq_in;
		end
	end
endmodule // motor_supply_model

// ---- verification/restart_chk.sv ----
// assertion checker bound to the restart sequencer ports
`timescale 1ns/1ps
module restart_chk #(
	parameter int TICK_CYCLES = 4000000
) (
	input wire logic mclk_in, // system clock
	input wire logic nrst_in, // async reset, low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb enable
	input wire logic pready_out, // apb ready
	input wire logic pslverr_out, // apb error
	input wire logic power_fail_in, // outage level
	input wire logic reset_input_in, // reset input
	input wire logic drive_enable_out, // stage on
	input wire logic matching_active_out, // matching
	input wire logic trip_out, // tripped
	input wire logic [3:0] trip_code_out, // trip cause
	input wire logic [4:0] current_limit_out, // limit
	input wire logic [14:0] decel_time_out // decel time
);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// the bus answers in the cycle after setup, for one cycle only
	chk_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	chk_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	chk_match_drive: assert property (
		matching_active_out |-> drive_enable_out)
		else $error("matching without drive");
	chk_trip_idle: assert property (trip_out |-> !drive_enable_out)
		else $error("drive on while tripped");
	chk_trip_code: assert property ($rose(trip_out) |-> ##[0:1]
		trip_code_out inside {4'h1, 4'h2, 4'h3, 4'h9})
		else $error("bad trip code");
	chk_outage_drop: assert property (
		power_fail_in && drive_enable_out |-> ##[1:2] !drive_enable_out)
		else $error("drive kept during outage");
	chk_reset_clear: assert property (reset_input_in |-> ##2 !trip_out)
		else $error("trip not cleared by reset");
	chk_limit_range: assert property (drive_enable_out |->
		current_limit_out inside {[5'h02:5'h14]})
		else $error("current limit out of range");
	chk_decel_range: assert property (drive_enable_out |->
		decel_time_out inside {[15'h0001:15'h7530]})
		else $error("decel time out of range");
	cov_match: cover property ($rose(matching_active_out));
	cov_trip: cover property ($rose(trip_out));
	cov_err: cover property (pslverr_out);
endmodule // restart_chk
bind restart_sequencer restart_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.mclk_in, .nrst_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
	.power_fail_in, .reset_input_in, .drive_enable_out,
	.matching_active_out, .trip_out, .trip_code_out, .current_limit_out,
	.decel_time_out);

// ---- verification/tb.sv ----
// self-checking bench for the restart sequencer
`timescale 1ns/1ps
`include "restart_regs.svh"
module tb;
	logic mclk_in = 1'h0, nrst_in = 1'h0, psel_in = 1'h0;
	logic penable_in = 1'h0, pwrite_in = 1'h0, run_terminal_in = 1'h0;
	logic keypad_run_in = 1'h0, coast_stop_input_in = 1'h0;
	logic reset_input_in = 1'h0, overcurrent_in = 1'h0;
	logic overvoltage_in = 1'h0, outage = 1'h0;
	logic [2:0] lag = 3'h1;
	logic [7:0] paddr_in = 8'h00;
	logic [15:0] max_freq_in = 16'h0, command_freq_in = 16'h0, frun = 16'h0;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rdat, seed = 32'h8DC8;
	logic pready_out, pslverr_out, irq_out, run_cmd_out, rerr, trip_out;
	logic drive_enable_out, matching_active_out, power_fail_in;
	logic [15:0] output_freq_in, start_freq_out;
	logic [4:0] current_limit_out;
	logic [14:0] decel_time_out;
	logic [3:0] trip_code_out;
	int err_total = 0;
	int n_checks = 0;
	int wcnt;
	int exp_q[$];
	always #12.5 mclk_in = ~mclk_in;
	// short tick so second-based timers finish in a few hundred cycles
	restart_sequencer #(.TICK_CYCLES(10)) i_restart_sequencer (.mclk_in,
		.nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out, .irq_out, .run_terminal_in,
		.keypad_run_in, .keypad_stop_in(1'h0), .coast_stop_input_in,
		.reset_input_in, .power_fail_in, .overcurrent_in, .overvoltage_in,
		.output_freq_in, .max_freq_in, .command_freq_in, .run_cmd_out,
		.drive_enable_out, .matching_active_out, .start_freq_out,
		.current_limit_out, .decel_time_out, .trip_out, .trip_code_out);
	motor_supply_model i_motor_supply_model (.mclk_in, .nrst_in,
		.outage_req_in(outage), .drive_enable_in(drive_enable_out),
		.matching_in(matching_active_out), .lag_in(lag),
		.run_freq_in(frun), .cmd_freq_in(command_freq_in),
		.power_fail_out(power_fail_in), .freq_out(output_freq_in));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic fail(input string nm);
		err_total++;
		$display("[ERR] %s exp done seen timeout", nm);
		test_done;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic sig(input int w);
		case (w)
			0: return drive_enable_out;
			1: return matching_active_out;
			2: return trip_out;
			default: return run_cmd_out;
		endcase
	endfunction
	// bounded wait; wcnt keeps the cycles taken
	task automatic wait_on(input int w, input logic v);
		for (wcnt = 0; wcnt < 3000; wcnt++) begin
			@(posedge mclk_in);
			if (sig(w) === v) return;
		end
		fail("wait");
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge mclk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'h1;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk_in);
			if (pready_out === 1'h1) break;
		end
		if (k == 20) fail("apb");
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), rdat, exp);
	endtask
	// one-cycle pulse: 0 reset, 1 keypad run, 2 overcurrent, 3 overvoltage
	task automatic pulse(input int w);
		@(posedge mclk_in);
		case (w)
			0: reset_input_in <= 1'h1;
			1: keypad_run_in <= 1'h1;
			2: overcurrent_in <= 1'h1;
			default: overvoltage_in <= 1'h1;
		endcase
		@(posedge mclk_in);
		{reset_input_in, keypad_run_in, overcurrent_in, overvoltage_in} <= 4'h0;
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (10) @(posedge mclk_in);
		nrst_in <= 1'h1;
		rdc(`CTRL_OFF, `CTRL_RST);
		rdc(`TIME_OFF, `TIME_RST);
		rdc(`MATCH_OFF, `MATCH_RST);
		chk("limit", current_limit_out, 32'hF);
		chk("decel", decel_time_out, 32'h1E);
		rdc(`IRQ_MASK_OFF, 32'h0);
		rdc(8'h20, 32'h0);
		chk("slverr", rerr, 32'h1);
		apb(1'h1, `IRQ_MASK_OFF, 32'h1);
		apb(1'h1, `TIME_OFF, 32'h0003_0005);
		seed = lfsr(seed);
		max_freq_in <= seed[15:0];
		seed = lfsr(seed);
		command_freq_in <= seed[31:16];
		run_terminal_in <= 1'h1;
		wait_on(0, 1'h1);
		// three start speeds with active matching, then plain matching
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, `CTRL_OFF, 32'h0001_0000 + ((s > 1 ? 2 : s) << 18)
				+ (s < 3 ? 4 : 2));
			seed = lfsr(seed);
			frun <= seed[15:0];
			lag <= 3'(s + 1);
			exp_q.push_back(s == 1 ? max_freq_in : s == 2 ?
				command_freq_in : seed[15:0]);
			repeat (4) @(posedge mclk_in);
			outage <= 1'h1;
			wait_on(0, 1'h0);
			repeat (3) @(posedge mclk_in);
			chk("irq", irq_out, 32'h1);
			chk("run", run_cmd_out, 32'h1);
			outage <= 1'h0;
			wait_on(1, 1'h1);
			chk("wait", 32'(wcnt > 19 && wcnt < 45), 32'h1);
			@(posedge mclk_in);
			chk("start", start_freq_out, exp_q.pop_front());
			rdc(`IRQ_STAT_OFF, 32'h3);
			wait_on(1, 1'h0);
			repeat (2) @(posedge mclk_in);
			chk("irq", irq_out, 32'h0);
		end
		outage <= 1'h1;
		wait_on(2, 1'h1);
		chk("tripwait", 32'(wcnt > 39), 32'h1);
		@(posedge mclk_in);
		chk("code", trip_code_out, `TRIP_OUTAGE_TIME);
		outage <= 1'h0;
		rdc(`IRQ_STAT_OFF, 32'h5);
		pulse(0);
		wait_on(2, 1'h0);
		@(posedge mclk_in);
		chk("code", trip_code_out, 32'h0);
		wait_on(0, 1'h1);
		apb(1'h1, `CTRL_OFF, 32'h0011_0020);
		pulse(2);
		wait_on(1, 1'h1);
		wait_on(1, 1'h0);
		pulse(3);
		wait_on(2, 1'h1);
		@(posedge mclk_in);
		chk("code", trip_code_out, `TRIP_OC);
		pulse(0);
		wait_on(0, 1'h1);
		apb(1'h1, `CTRL_OFF, 32'h0001_2100);
		pulse(1);
		wait_on(3, 1'h1);
		coast_stop_input_in <= 1'h1;
		repeat (3) @(posedge mclk_in);
		chk("run", run_cmd_out, 32'h0);
		coast_stop_input_in <= 1'h0;
		repeat (5) @(posedge mclk_in);
		chk("run", run_cmd_out, 32'h0);
		pulse(1);
		wait_on(0, 1'h1);
		chk("hold", 32'(wcnt > 19), 32'h1);
		test_done;
	end
endmodule // tb
